// ---- pcs_consts.vh ----
// Summary of operation
// - On a turn-off message, pull the notice low and keep sampling the acknowledge.
// - Outputs mirror power control/status: enable bit 8, status bit 15, state 1:0.
// - Enabled-status output is high while configuration software has enabled MSI-X.
// - Function-mask output follows the function mask bit of MSI-X message control.
// - A dedicated bus shows the device control 2 register of the express capability.
// - User writes 32-bit config data with low-active enable; only enabled bytes change.
// - Reference clock frequency is a build-time choice of 100, 125 or 250 MHz.
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// Register byte addresses
`define PCS_REG_CTRL      8'h00
`define PCS_REG_STATUS    8'h04
`define PCS_REG_MASK      8'h08
`define PCS_REG_STATE     8'h0C
`define PCS_REG_CFG_ADDR  8'h10
`define PCS_REG_CFG_DATA  8'h14
`define PCS_REG_INFO      8'h18

// Control bits
`define PCS_CTRL_SW_TURNOFF 0
`define PCS_CTRL_RST        1'h0

// Event bits in status and mask
`define PCS_EV_TURNOFF_RX  0
`define PCS_EV_TURNOFF_ACK 1
`define PCS_EV_USER_WRITE  2
`define PCS_EV_WIDTH       3

// Config space word indexes of mirrored registers
`define PCS_IDX_PMCSR     6'h11
`define PCS_IDX_MSIX_CTL  6'h12
`define PCS_IDX_DEVCTL2   6'h22

// Field positions
`define PCS_PM_PME_EN     8
`define PCS_PM_PME_STATUS 15
`define PCS_PM_STATE_HI   1
`define PCS_PM_STATE_LO   0
`define PCS_MSIX_ENABLE   31
`define PCS_MSIX_FMASK    30
`define PCS_DC2_HI        15
`define PCS_DC2_LO        0

// Reference clock choices
`define PCS_REFCLK_100    100
`define PCS_REFCLK_125    125
`define PCS_REFCLK_250    250
`define PCS_REFCODE_100   2'h0
`define PCS_REFCODE_125   2'h1
`define PCS_REFCODE_250   2'h2
`define PCS_REFCODE_BAD   2'h3

// Turn-off handshake states
`define PCS_ST_IDLE       1'b0
`define PCS_ST_WAIT       1'b1

`endif

// ---- pcs_cfg_mem.v ----
`timescale 1ns/10ps
`default_nettype none
module pcs_cfg_mem #(
    parameter AW = 6,
    parameter DW = 32
) (
    // Clock
    input  wire          clk,
    // Write port
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [DW/8-1:0] wbe,
    // Read port
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer      i;

    always @(posedge clk) begin
        if (we) begin
            for (i = 0; i < DW/8; i = i + 1) begin
                if (wbe[i]) begin
                    mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
                end
            end
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ---- pcs_sideband.v ----
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.vh"
module pcs_sideband #(
    parameter REF_CLK_MHZ = `PCS_REFCLK_100,
    parameter CFG_AW      = 6,
    parameter PAW         = 8
) (
    // Clock and reset
    input  wire              sys_clk,
    input  wire              rst,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [PAW-1:0]    paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // Interrupt
    output reg               irq,
    // User configuration write port
    input  wire [31:0]       cfg_write_data,
    input  wire              cfg_write_en_low,
    input  wire [3:0]        cfg_byte_en_low,
    input  wire [CFG_AW-1:0] cfg_write_addr,
    // Turn-off handshake
    input  wire              turnoff_msg_in,
    input  wire              turnoff_ok_low,
    output reg               turnoff_notice_low,
    output reg               pme_to_ack_out,
    // Status mirrors
    output wire              pm_pme_enable,
    output wire              pm_pme_status,
    output wire [1:0]        pm_power_state,
    output wire              msix_enabled,
    output wire              msix_func_mask,
    output wire [15:0]       device_control_two_out
);
    // Pin synchronisers
    reg                     msg_s1;
    reg                     msg_s2;
    reg                     msg_s3;
    reg                     ok_s1;
    reg                     ok_s2;

    // Handshake state
    reg                     hs_state;
    reg                     sw_turnoff;

    // Registers
    reg  [`PCS_EV_WIDTH-1:0] status;
    reg  [`PCS_EV_WIDTH-1:0] mask;
    reg  [CFG_AW-1:0]       cfg_addr;
    reg                     apb_pend;
    reg  [31:0]             apb_data;
    reg  [CFG_AW-1:0]       apb_addr;

    // Config shadows
    reg  [31:0]             pmcsr;
    reg  [31:0]             msix_ctl;
    reg  [31:0]             devctl2;

    wire [31:0]             mem_rdata;
    wire                    msg_rise;
    wire                    usr_wr;
    wire                    wr_go;
    wire [CFG_AW-1:0]       wr_addr;
    wire [31:0]             wr_data;
    wire [3:0]              wr_be;
    wire                    apb_setup;
    wire                    apb_wr;
    wire                    turnoff_start;
    wire                    turnoff_done;
    wire [1:0]              ref_code;
    reg  [`PCS_EV_WIDTH-1:0] events;
    reg  [`PCS_EV_WIDTH-1:0] next_status;
    reg  [31:0]             rd_mux;

    // Byte-lane merge of a config word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] new_val;
        input [3:0]  be;
        integer      k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    merge[k*8 +: 8] = new_val[k*8 +: 8];
                end
            end
        end
    endfunction

    // Address lies on the register map
    function mapped;
        input [PAW-1:0] a;
        begin
            case (a)
                `PCS_REG_CTRL, `PCS_REG_STATUS, `PCS_REG_MASK,
                `PCS_REG_STATE, `PCS_REG_CFG_ADDR, `PCS_REG_CFG_DATA,
                `PCS_REG_INFO: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    // Frequency chosen at build time, reported to software
    assign ref_code = (REF_CLK_MHZ == `PCS_REFCLK_100) ? `PCS_REFCODE_100 :
                      (REF_CLK_MHZ == `PCS_REFCLK_125) ? `PCS_REFCODE_125 :
                      (REF_CLK_MHZ == `PCS_REFCLK_250) ? `PCS_REFCODE_250 :
                      `PCS_REFCODE_BAD;

    always @(posedge sys_clk) begin
        if (rst) begin
            msg_s1 <= 1'b0;
            msg_s2 <= 1'b0;
            msg_s3 <= 1'b0;
            ok_s1  <= 1'b1;
            ok_s2  <= 1'b1;
        end else begin
            msg_s1 <= turnoff_msg_in;
            msg_s2 <= msg_s1;
            msg_s3 <= msg_s2;
            ok_s1  <= turnoff_ok_low;
            ok_s2  <= ok_s1;
        end
    end

    assign msg_rise      = msg_s2 & ~msg_s3;
    assign turnoff_start = (hs_state == `PCS_ST_IDLE) & (msg_rise | sw_turnoff);
    // Acknowledge trusted only once user logic is drained
    assign turnoff_done  = (hs_state == `PCS_ST_WAIT) & ~ok_s2;

    // Turn-off handshake
    always @(posedge sys_clk) begin
        if (rst) begin
            hs_state           <= `PCS_ST_IDLE;
            turnoff_notice_low <= 1'b1;
            pme_to_ack_out     <= 1'b0;
        end else begin
            pme_to_ack_out <= 1'b0;
            case (hs_state)
                `PCS_ST_IDLE: begin
                    if (turnoff_start) begin
                        turnoff_notice_low <= 1'b0;
                        hs_state           <= `PCS_ST_WAIT;
                    end
                end
                `PCS_ST_WAIT: begin
                    // Poll every cycle until user agrees
                    if (turnoff_done) begin
                        turnoff_notice_low <= 1'b1;
                        pme_to_ack_out     <= 1'b1;
                        hs_state           <= `PCS_ST_IDLE;
                    end
                end
                default: begin
                    hs_state           <= `PCS_ST_IDLE;
                    turnoff_notice_low <= 1'b1;
                end
            endcase
        end
    end

    // Config write arbitration; user port wins, APB word waits until the user port is idle
    assign usr_wr  = ~cfg_write_en_low;
    assign wr_go   = usr_wr | apb_pend;
    assign wr_addr = usr_wr ? cfg_write_addr : apb_addr;
    assign wr_data = usr_wr ? cfg_write_data : apb_data;
    assign wr_be   = usr_wr ? ~cfg_byte_en_low : 4'hF;

    pcs_cfg_mem #(
        .AW (CFG_AW),
        .DW (32)
    ) u_mem (
        .clk   (sys_clk),
        .we    (wr_go),
        .waddr (wr_addr),
        .wdata (wr_data),
        .wbe   (wr_be),
        .raddr (cfg_addr),
        .rdata (mem_rdata)
    );

    // Shadows of mirrored config words
    always @(posedge sys_clk) begin
        if (rst) begin
            pmcsr    <= 32'h0000_0000;
            msix_ctl <= 32'h0000_0000;
            devctl2  <= 32'h0000_0000;
        end else if (wr_go) begin
            if (wr_addr == `PCS_IDX_PMCSR) begin
                pmcsr <= merge(pmcsr, wr_data, wr_be);
            end
            if (wr_addr == `PCS_IDX_MSIX_CTL) begin
                msix_ctl <= merge(msix_ctl, wr_data, wr_be);
            end
            if (wr_addr == `PCS_IDX_DEVCTL2) begin
                devctl2 <= merge(devctl2, wr_data, wr_be);
            end
        end
    end

    assign pm_pme_enable  = pmcsr[`PCS_PM_PME_EN];
    assign pm_pme_status  = pmcsr[`PCS_PM_PME_STATUS];
    assign pm_power_state = pmcsr[`PCS_PM_STATE_HI:`PCS_PM_STATE_LO];
    assign msix_enabled   = msix_ctl[`PCS_MSIX_ENABLE];
    assign msix_func_mask = msix_ctl[`PCS_MSIX_FMASK];
    assign device_control_two_out = devctl2[`PCS_DC2_HI:`PCS_DC2_LO];

    // APB phases
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pready & pwrite;

    // Events and sticky status; a new event beats a same-cycle clear
    always @* begin
        events = {`PCS_EV_WIDTH{1'b0}};
        events[`PCS_EV_TURNOFF_RX]  = turnoff_start;
        events[`PCS_EV_TURNOFF_ACK] = turnoff_done;
        events[`PCS_EV_USER_WRITE]  = usr_wr;
        next_status = status;
        if (apb_wr && paddr == `PCS_REG_STATUS) begin
            next_status = status & ~pwdata[`PCS_EV_WIDTH-1:0];
        end
        next_status = next_status | events;
    end

    // Read mux, sampled in the setup cycle
    always @* begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `PCS_REG_CTRL:     rd_mux[`PCS_CTRL_SW_TURNOFF] = sw_turnoff;
            `PCS_REG_STATUS:   rd_mux[`PCS_EV_WIDTH-1:0] = status;
            `PCS_REG_MASK:     rd_mux[`PCS_EV_WIDTH-1:0] = mask;
            `PCS_REG_STATE:    rd_mux[10:0] = {device_control_two_out[3:0],
                                               msix_func_mask, msix_enabled,
                                               pm_power_state, pm_pme_status,
                                               pm_pme_enable, hs_state};
            `PCS_REG_CFG_ADDR: rd_mux[CFG_AW-1:0] = cfg_addr;
            `PCS_REG_CFG_DATA: rd_mux = mem_rdata;
            `PCS_REG_INFO:     rd_mux[1:0] = ref_code;
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // Register file and bus answer
    always @(posedge sys_clk) begin
        if (rst) begin
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            irq        <= 1'b0;
            status     <= {`PCS_EV_WIDTH{1'b0}};
            mask       <= {`PCS_EV_WIDTH{1'b0}};
            sw_turnoff <= `PCS_CTRL_RST;
            cfg_addr   <= {CFG_AW{1'b0}};
            apb_pend   <= 1'b0;
            apb_data   <= 32'h0000_0000;
            apb_addr   <= {CFG_AW{1'b0}};
        end else begin
            // Single wait-free access phase
            pready  <= apb_setup;
            pslverr <= apb_setup & ~mapped(paddr);
            if (apb_setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            end
            status <= next_status;
            irq    <= |(next_status & mask);
            // Software request is a one-shot; taken only while idle
            if (turnoff_start) begin
                sw_turnoff <= 1'b0;
            end
            if (apb_pend && !usr_wr) begin
                apb_pend <= 1'b0;
            end
            if (apb_wr) begin
                case (paddr)
                    `PCS_REG_CTRL: begin
                        sw_turnoff <= pwdata[`PCS_CTRL_SW_TURNOFF];
                    end
                    `PCS_REG_MASK: begin
                        mask <= pwdata[`PCS_EV_WIDTH-1:0];
                    end
                    `PCS_REG_CFG_ADDR: begin
                        cfg_addr <= pwdata[CFG_AW-1:0];
                    end
                    `PCS_REG_CFG_DATA: begin
                        apb_pend <= 1'b1;
                        apb_data <= pwdata;
                        apb_addr <= cfg_addr;
                    end
                    default: begin
                        apb_pend <= apb_pend & usr_wr;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- pcs_sideband_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.vh"
module pcs_sideband_asserts #(
    parameter CFG_AW = 6
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              rst,
    // Bus answer
    input wire logic              pready,
    input wire logic              pslverr,
    // User configuration write
    input wire logic [31:0]       cfg_write_data,
    input wire logic              cfg_write_en_low,
    input wire logic [3:0]        cfg_byte_en_low,
    input wire logic [CFG_AW-1:0] cfg_write_addr,
    // Turn-off handshake
    input wire logic              turnoff_msg_in,
    input wire logic              turnoff_ok_low,
    input wire logic              turnoff_notice_low,
    input wire logic              pme_to_ack_out,
    // Mirrors
    input wire logic              pm_pme_enable,
    input wire logic              pm_pme_status,
    input wire logic [1:0]        pm_power_state,
    input wire logic              msix_enabled,
    input wire logic              msix_func_mask,
    input wire logic [15:0]       device_control_two_out
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    wire pm_wr = !cfg_write_en_low && cfg_write_addr == `PCS_IDX_PMCSR;
    wire mx_wr = !cfg_write_en_low && cfg_write_addr == `PCS_IDX_MSIX_CTL;
    wire dc_wr = !cfg_write_en_low && cfg_write_addr == `PCS_IDX_DEVCTL2;

    property p_pm_low;
        pm_wr && !cfg_byte_en_low[0] |=> pm_power_state == $past(cfg_write_data[1:0]);
    endproperty
    a_pm_low: assert property (p_pm_low)
        else $error("power state mirror wrong");
    property p_pm_hi;
        pm_wr && !cfg_byte_en_low[1]
        |=> {pm_pme_status, pm_pme_enable} == $past({cfg_write_data[15], cfg_write_data[8]});
    endproperty
    a_pm_hi: assert property (p_pm_hi)
        else $error("pme mirrors wrong");
    property p_keep;
        pm_wr && cfg_byte_en_low[1] |=> $stable({pm_pme_status, pm_pme_enable});
    endproperty
    a_keep: assert property (p_keep)
        else $error("disabled byte changed");
    property p_msix;
        mx_wr && !cfg_byte_en_low[3]
        |=> {msix_enabled, msix_func_mask} == $past(cfg_write_data[31:30]);
    endproperty
    a_msix: assert property (p_msix)
        else $error("msix mirrors wrong");
    property p_dc2;
        dc_wr && cfg_byte_en_low[1:0] == 2'b00
        |=> device_control_two_out == $past(cfg_write_data[15:0]);
    endproperty
    a_dc2: assert property (p_dc2)
        else $error("device control two mirror wrong");
    property p_notice_fall;
        $rose(turnoff_msg_in) && turnoff_notice_low |-> ##[2:4] !turnoff_notice_low;
    endproperty
    a_notice_fall: assert property (p_notice_fall)
        else $error("notice did not fall");
    property p_notice_rise;
        $rose(turnoff_notice_low) |-> pme_to_ack_out && !$past(turnoff_ok_low, 2);
    endproperty
    a_notice_rise: assert property (p_notice_rise)
        else $error("notice released without acknowledge");
    property p_ack_pulse;
        pme_to_ack_out |=> !pme_to_ack_out && turnoff_notice_low;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack pulse too long");

    c_ack: cover property (pme_to_ack_out);
    c_keep: cover property (pm_wr && cfg_byte_en_low[1]);
    c_err: cover property (pready && pslverr);
endmodule
`default_nettype wire

// ---- pcs_user_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcs_user_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Turn-off handshake
    input  wire logic       turnoff_notice_low,
    input  wire logic [7:0] drain_cycles,
    output var  logic       turnoff_ok_low
);
    logic [7:0] busy_cnt;

    // Traffic stays on class 0, channel 0; no channel capability here
    // Vector table and pending array live in this logic, not the block

    // Acknowledge only once queued work has drained
    always @(posedge sys_clk) begin
        if (rst || turnoff_notice_low) begin
            turnoff_ok_low <= 1'b1;
            busy_cnt       <= 8'h00;
        end else if (busy_cnt == drain_cycles) begin
            turnoff_ok_low <= 1'b0;
        end else begin
            busy_cnt <= busy_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.vh"
module testbench;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] cfg_write_data = 32'h0;
    logic        cfg_write_en_low = 1'b1;
    logic [3:0]  cfg_byte_en_low = 4'hF;
    logic [5:0]  cfg_write_addr = 6'h00;
    logic        turnoff_msg_in = 1'b0;
    logic [7:0]  drain = 8'h00;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, er, turnoff_ok_low, turnoff_notice_low;
    logic        pme_to_ack_out, pm_pme_enable, pm_pme_status, msix_enabled, msix_func_mask;
    logic [1:0]  pm_power_state;
    logic [15:0] device_control_two_out;
    int          miscompares = 0;
    int          num_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    pcs_sideband #(.REF_CLK_MHZ(125)) u_pcs_sideband (.sys_clk, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .cfg_write_data,
        .cfg_write_en_low, .cfg_byte_en_low, .cfg_write_addr, .turnoff_msg_in,
        .turnoff_ok_low, .turnoff_notice_low, .pme_to_ack_out, .pm_pme_enable,
        .pm_pme_status, .pm_power_state, .msix_enabled, .msix_func_mask,
        .device_control_two_out);
    pcs_user_model u_pcs_user_model (.sys_clk, .rst, .turnoff_notice_low,
        .drain_cycles(drain), .turnoff_ok_low);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (pready !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: bus answer timed out", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic uw(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge sys_clk);
        cfg_write_en_low <= 1'b0;
        cfg_write_addr <= a;
        cfg_byte_en_low <= be;
        cfg_write_data <= d;
        @(posedge sys_clk);
        cfg_write_en_low <= 1'b1;
        @(posedge sys_clk);
    endtask

    task automatic t_regs;
        apb(1'b0, `PCS_REG_INFO, 32'h0);
        chk(rd, `PCS_REFCODE_125, "clock code");
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0000_0000, "unmapped read data");
        chk({31'h0, er}, 32'h0000_0001, "unmapped read error");
        $display("test regs done");
    endtask

    task automatic t_mirror;
        uw(`PCS_IDX_PMCSR, 4'h0, 32'h0000_8103);
        chk({pm_pme_status, pm_pme_enable, pm_power_state}, 4'hF, "pm all");
        uw(`PCS_IDX_PMCSR, 4'hD, 32'h0);
        chk({pm_pme_status, pm_pme_enable, pm_power_state}, 4'h3, "pm byte1");
        uw(`PCS_IDX_PMCSR, 4'hE, 32'hFFFF_FF02);
        chk({pm_pme_status, pm_pme_enable, pm_power_state}, 4'h2, "pm byte0");
        uw(`PCS_IDX_MSIX_CTL, 4'h7, 32'hC000_0000);
        chk({msix_enabled, msix_func_mask}, 2'h3, "msix on");
        uw(`PCS_IDX_MSIX_CTL, 4'h7, 32'h4000_0000);
        chk({msix_enabled, msix_func_mask}, 2'h1, "msix mask");
        uw(`PCS_IDX_DEVCTL2, 4'hC, 32'hFFFF_1235);
        chk(device_control_two_out, 16'h1235, "dc2");
        apb(1'b0, `PCS_REG_STATE, 32'h0);
        chk(rd, 32'h0000_02D0, "state word");
        $display("test mirrors done");
    endtask

    task automatic t_cfg_apb;
        apb(1'b1, `PCS_REG_CFG_ADDR, 32'h0000_0022);
        apb(1'b1, `PCS_REG_CFG_DATA, 32'h0000_ABCD);
        repeat (2) @(posedge sys_clk);
        chk(device_control_two_out, 16'hABCD, "dc2 by bus");
        apb(1'b0, `PCS_REG_CFG_DATA, 32'h0);
        chk(rd, 32'h0000_ABCD, "cfg readback");
        $display("test cfg bus done");
    endtask

    task automatic t_irq;
        apb(1'b1, `PCS_REG_MASK, 32'h0000_0007);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1, "irq on user write");
        apb(1'b1, `PCS_REG_STATUS, 32'h0000_0007);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0, "irq cleared");
        $display("test irq done");
    endtask

    task automatic t_off(input logic [7:0] dly, input logic sw);
        int n;
        drain <= dly;
        if (sw) begin
            apb(1'b1, `PCS_REG_CTRL, 32'h0000_0001);
        end else begin
            @(posedge sys_clk);
            turnoff_msg_in <= 1'b1;
        end
        n = 0;
        while (turnoff_notice_low !== 1'b0 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        chk(n < 20, 1'b1, "notice low");
        turnoff_msg_in <= 1'b0;
        // A repeated message while waiting must not restart the handshake
        if (dly > 8'd5) begin
            repeat (2) @(posedge sys_clk);
            turnoff_msg_in <= 1'b1;
            repeat (2) @(posedge sys_clk);
            turnoff_msg_in <= 1'b0;
        end
        n = 0;
        while (pme_to_ack_out !== 1'b1 && n < 60) begin
            @(posedge sys_clk);
            n++;
        end
        chk({turnoff_notice_low, pme_to_ack_out}, 2'h3, "ack");
        if (dly > 8'd5) begin
            repeat (8) @(posedge sys_clk);
            chk(turnoff_notice_low, 1'b1, "no restart");
        end
        chk(irq, 1'b1, "irq on turn-off");
        apb(1'b0, `PCS_REG_STATUS, 32'h0);
        chk(rd[1:0], 2'h3, "status");
        apb(1'b1, `PCS_REG_STATUS, 32'h0000_0003);
        $display("test turn-off done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        wrap_up;
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs;
        t_mirror;
        t_cfg_apb;
        t_irq;
        t_off(8'd0, 1'b0);
        t_off(8'd20, 1'b0);
        t_off(8'd3, 1'b1);
        wrap_up;
    end
endmodule

bind pcs_sideband pcs_sideband_asserts #(.CFG_AW(CFG_AW)) u_pcs_sideband_asserts (
    .sys_clk, .rst, .pready, .pslverr, .cfg_write_data, .cfg_write_en_low,
    .cfg_byte_en_low, .cfg_write_addr, .turnoff_msg_in, .turnoff_ok_low,
    .turnoff_notice_low, .pme_to_ack_out, .pm_pme_enable, .pm_pme_status,
    .pm_power_state, .msix_enabled, .msix_func_mask, .device_control_two_out);
`default_nettype wire
